// [verilog/ssc_mem_end.sv]
// Purpose: memory end of the command bus; registers the synchronous
// inputs, decodes the command and runs the two-bit burst counter
// Assumes: bus inputs come from logic on clk_sys, so they need no
// synchroniser; the burst-order strap is a pin and passes two flops
// before anything reads it
// Notes: no reset, as the part has none; outputs are unknown until the
// first qualified load; a raised qualify freezes every register but
// the strap synchroniser, and does not end the selection
// or the burst in progress
`timescale 1ns/100ps
module ssc_mem_end #(
	parameter int ADDR_W = ssc_pkg::ADDR_W,
	parameter int LANES = ssc_pkg::LANES,
	parameter int LANE_W = ssc_pkg::LANE_W
) (
	input wire logic clk_sys,
	ssc_if.mem bus,
	input wire logic burst_interleave,
	output logic [ADDR_W-1:0] cur_addr,
	output ssc_pkg::ssc_op_t cur_op,
	output logic [LANES-1:0] lane_write_en,
	output logic [LANES*LANE_W-1:0] wdata_out,
	output logic [LANES-1:0] parity_out
);
	import ssc_pkg::*;

	// low address bits of one beat, in the order the strap picks
	function automatic logic [BURST_W-1:0] beat_low(
		input logic [BURST_W-1:0] start,
		input logic [BURST_W-1:0] beat,
		input logic interleave
	);
		logic [BURST_W-1:0] low;
		if (interleave) begin
			low = start ^ beat; // R15
		end else begin
			low = BURST_W'(start + beat); // R15
		end
		return low;
	endfunction : beat_low

	// strap pin crosses in from outside the clock domain
	logic strap_meta_reg;
	logic strap_sync_reg;
	logic strap_reg;
	logic strap_next;

	// command decode
	logic qualified;
	logic selected;
	logic load_cycle;
	logic advance_cycle;
	logic write_beat;
	ssc_op_t load_op;
	ssc_op_t op_reg;
	ssc_op_t op_next;

	// burst address
	logic [ADDR_W-1:0] base_reg;
	logic [ADDR_W-1:0] base_next;
	logic [BURST_W-1:0] beat_reg;
	logic [BURST_W-1:0] beat_next;
	logic [ADDR_W-1:0] addr_reg;
	logic [ADDR_W-1:0] addr_next;

	always_ff @(posedge clk_sys) begin
		strap_meta_reg <= burst_interleave;
		strap_sync_reg <= strap_meta_reg;
	end

	// an edge counts only while qualify is low
	assign qualified = !bus.clock_qualify_n; // R9 R14

	// all three selects at active level on the same edge
	assign selected = !bus.chip_sel_low_a // R11
		&& bus.chip_sel_high // R12
		&& !bus.chip_sel_low_b; // R11 R13

	assign load_cycle = qualified && !bus.advance_load_n; // R7
	assign advance_cycle = qualified
		&& bus.advance_load_n; // R6

	// strap is meant to stay put; sampled on qualified edges only
	always_comb begin
		strap_next = strap_reg;
		if (qualified) begin
			strap_next = strap_sync_reg; // R15
		end
	end

	always_ff @(posedge clk_sys) begin
		strap_reg <= strap_next;
	end

	// what a load starts: nothing unless selected
	always_comb begin
		if (!selected) begin
			load_op = SSC_IDLE; // R13 R18
		end else if (!bus.write_n) begin
			load_op = SSC_WRITE; // R4 R5
		end else begin
			load_op = SSC_READ; // R4
		end
	end

	// command state; an advance keeps the burst's command
	always_comb begin
		op_next = op_reg;
		case (op_reg)
			SSC_IDLE: begin
				// an advance while idle starts nothing
				if (load_cycle) begin
					op_next = load_op; // R7
				end
			end
			SSC_READ, SSC_WRITE: begin
				if (load_cycle) begin
					op_next = load_op; // R7 R18
				end else if (advance_cycle) begin
					op_next = op_reg; // R6
				end
			end
			default: begin
				op_next = SSC_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		op_reg <= op_next;
	end

	// a load keeps the old base when deselected
	always_comb begin
		base_next = base_reg;
		if (load_cycle && selected) begin
			base_next = bus.addr; // R1 R10
		end
	end

	// two-bit counter: cleared on a load, stepped on an advance while a burst is running
	always_comb begin
		beat_next = beat_reg;
		if (load_cycle) begin
			beat_next = BEAT_ZERO;
		end else if (advance_cycle
			&& op_reg != SSC_IDLE) begin
			beat_next = BURST_W'(beat_reg + BEAT_ONE); // R6 R17
		end
	end

	// beat address wraps within its group of four
	always_comb begin
		addr_next = {base_next[ADDR_W-1:BURST_W],
			beat_low(base_next[BURST_W-1:0], beat_next,
			strap_next)}; // R17
	end

	always_ff @(posedge clk_sys) begin
		base_reg <= base_next;
		beat_reg <= beat_next;
		addr_reg <= addr_next;
	end

	assign cur_addr = addr_reg;
	assign cur_op = op_reg;

	// lanes are written only in a qualified write beat
	assign write_beat = qualified
		&& op_next == SSC_WRITE; // R3

	// one lane: eight data bits, their parity bit and a write enable
	generate
		for (genvar i = 0; i < LANES; i++) begin : g_lane
			logic wen_reg;
			logic wen_next;
			logic [LANE_W-1:0] wd_reg;
			logic [LANE_W-1:0] wd_next;
			logic par_reg;
			logic par_next;

			always_comb begin
				if (qualified) begin // R10 R14
					wd_next =
						bus.wdata[i*LANE_W +: LANE_W]; // R16
					par_next = bus.parity_lane[i]; // R3 R16
					wen_next = write_beat
						&& !bus.byte_write_sel_n[i]; // R2 R3
				end else begin
					wd_next = wd_reg;
					par_next = par_reg;
					wen_next = wen_reg;
				end
			end

			always_ff @(posedge clk_sys) begin
				wen_reg <= wen_next;
				wd_reg <= wd_next;
				par_reg <= par_next;
			end

			assign lane_write_en[i] = wen_reg;
			assign wdata_out[i*LANE_W +: LANE_W] = wd_reg;
			assign parity_out[i] = par_reg;
		end
	endgenerate
endmodule : ssc_mem_end

// [include/ssc_pkg.sv]
// Purpose: shared constants and types for the sram command-input stage
// Assumes: one clock, synchronous active-low reset on the controller end
// Notes: the memory end has no reset of its own, as the part has none
// Contract
// R1 - capture whole address on qualified rising edge
// R2 - byte write selects are active low
// R3 - each select gates its data lane and parity
// R4 - write strobe sampled only when qualify low
// R5 - controller drives write strobe low at start
// R6 - advance high with qualify low: counter increments
// R7 - advance low loads new external address
// R8 - controller loads fresh address after deselect
// R9 - edges with qualify high are ignored
// R10 - all synchronous inputs registered on qualified edge
// R11 - first and third chip selects active low
// R12 - second chip select active high
// R13 - selected only when all three selects active
// R14 - qualify high holds registers, keeps selection
// R15 - strap chooses interleaved or linear burst order
// R16 - write data captured into data register
// R17 - counter covers two low bits, four beats
// R18 - deselect with load stops burst, starts nothing
package ssc_pkg;
	localparam int ADDR_W = 20;
	localparam int LANES = 4;
	localparam int LANE_W = 8;
	localparam int BURST_W = 2;
	localparam logic [1:0] BEAT_ZERO = 2'h0;
	localparam logic [1:0] BEAT_ONE = 2'h1;
	localparam logic [1:0] BEAT_LAST = 2'h3;
	typedef enum logic [1:0] {SSC_IDLE, SSC_READ, SSC_WRITE} ssc_op_t;
endpackage : ssc_pkg

// [include/ssc_if.sv]
// Purpose: synchronous sram command bus between controller and memory
// Assumes: data lanes are modelled one-way, write direction only
// Notes: no clocking block; testbench joins the two ends here
`timescale 1ns/100ps
interface ssc_if #(
	parameter int ADDR_W = ssc_pkg::ADDR_W,
	parameter int LANES = ssc_pkg::LANES,
	parameter int LANE_W = ssc_pkg::LANE_W
);
	logic [ADDR_W-1:0] addr;
	logic chip_sel_low_a;
	logic chip_sel_high;
	logic chip_sel_low_b;
	logic write_n;
	logic [LANES-1:0] byte_write_sel_n;
	logic advance_load_n;
	logic clock_qualify_n;
	logic [LANES*LANE_W-1:0] wdata;
	logic [LANES-1:0] parity_lane;
	modport ctrl (output addr, chip_sel_low_a, chip_sel_high, chip_sel_low_b,
		write_n, byte_write_sel_n, advance_load_n, clock_qualify_n, wdata,
		parity_lane);
	modport mem (input addr, chip_sel_low_a, chip_sel_high, chip_sel_low_b,
		write_n, byte_write_sel_n, advance_load_n, clock_qualify_n, wdata,
		parity_lane);
endinterface : ssc_if

// [verilog/ssc_ctrl_end.sv]
// Purpose: controller end: turns user requests into bus commands
// Assumes: user holds req until ack; one command per qualified cycle
// Notes: all bus outputs registered; qualify driven from user hold
`timescale 1ns/100ps
module ssc_ctrl_end #(
	parameter int ADDR_W = ssc_pkg::ADDR_W,
	parameter int LANES = ssc_pkg::LANES,
	parameter int LANE_W = ssc_pkg::LANE_W
) (
	input wire logic clk_sys,
	input wire logic resetn,
	ssc_if.ctrl bus,
	input wire logic req,
	input wire logic req_write,
	input wire logic req_advance,
	input wire logic req_hold,
	input wire logic [ADDR_W-1:0] req_addr,
	input wire logic [LANES-1:0] req_lanes,
	input wire logic [LANES*LANE_W-1:0] req_wdata,
	input wire logic [LANES-1:0] req_parity,
	output logic ack
);
	import ssc_pkg::*;
	logic desel_reg, desel_next;
	logic ack_next;

	always_comb begin
		desel_next = desel_reg;
		ack_next = 1'b0;
		if (req_hold) begin
			ack_next = 1'b0;
		end else if (req) begin
			desel_next = 1'b0;
			ack_next = 1'b1;
		end else begin
			desel_next = 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			desel_reg <= 1'b1;
			ack <= 1'b0;
			bus.addr <= '0;
			bus.chip_sel_low_a <= 1'b1;
			bus.chip_sel_high <= 1'b0;
			bus.chip_sel_low_b <= 1'b1;
			bus.write_n <= 1'b1;
			bus.byte_write_sel_n <= '1;
			bus.advance_load_n <= 1'b0;
			bus.clock_qualify_n <= 1'b0;
			bus.wdata <= '0;
			bus.parity_lane <= '0;
		end else begin
			desel_reg <= desel_next;
			ack <= ack_next;
			bus.clock_qualify_n <= req_hold;
			if (!req_hold) begin
				bus.chip_sel_low_a <= !req; // R11
				bus.chip_sel_high <= req; // R12
				bus.chip_sel_low_b <= !req; // R11
				bus.write_n <= !(req && req_write); // R5
				bus.byte_write_sel_n <= (req && req_write) ?
					~req_lanes : '1; // R2
				// after a deselect always load a fresh address
				bus.advance_load_n <= req && req_advance && !desel_reg; // R8
				bus.addr <= req_addr;
				bus.wdata <= req_wdata;
				bus.parity_lane <= req_parity;
			end
		end
	end
endmodule : ssc_ctrl_end

// [tb/ssc_props.sv]
// Purpose: command bus checks
// Assumes: one clock domain
// Notes: watches the controller side
`timescale 1ns/100ps
module ssc_props (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic [ssc_pkg::ADDR_W-1:0] addr,
	input wire logic chip_sel_low_a,
	input wire logic chip_sel_high,
	input wire logic chip_sel_low_b,
	input wire logic write_n,
	input wire logic [ssc_pkg::LANES-1:0] byte_write_sel_n,
	input wire logic advance_load_n,
	input wire logic clock_qualify_n
);
	import ssc_pkg::*;
	wire sel = !chip_sel_low_a && chip_sel_high && !chip_sel_low_b;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	sequence desel_s; !clock_qualify_n && !sel; endsequence
	sequence sel_s; !clock_qualify_n && sel; endsequence
	fresh_load_a:
	assert property (desel_s ##1 sel_s |-> !advance_load_n)
	else $error("advance after deselect");
	write_sel_a:
	assert property (!write_n |-> sel)
	else $error("write while deselected");
	hold_bus_a:
	assert property (clock_qualify_n |-> $stable(addr) && $stable(write_n))
	else $error("bus moved during hold");
	lanes_idle_a:
	assert property (write_n |-> byte_write_sel_n == '1)
	else $error("lane select without write");
	desel_load_a:
	assert property (!sel |-> !advance_load_n)
	else $error("advance while deselected");
	hold_sel_a:
	assert property (clock_qualify_n
		|-> $stable(sel) && $stable(advance_load_n))
	else $error("selection moved during hold");
endmodule : ssc_props

// [tb/sync_sram_command_inputs_tb.sv]
// Purpose: random bench for both ends
// Assumes: one command per cycle
// Notes: memory outputs lag requests by two edges
`timescale 1ns/100ps
module sync_sram_command_inputs_tb;
	import ssc_pkg::*;
	localparam int N = 400;
	logic clk_sys = 0, resetn = 0, req = 0, req_write = 0, req_advance = 0;
	logic req_hold = 0, burst_interleave = 0, ack, il = 0;
	logic [ADDR_W-1:0] req_addr = '0, cur_addr, base = '0;
	logic [3:0] req_lanes = '0, req_parity = '0, lane_write_en, parity_out;
	logic [31:0] req_wdata = '0, wdata_out;
	logic [3:0] mln = '0, mpa = '0;
	logic [31:0] mwd = '0;
	logic [1:0] k = '0;
	ssc_op_t cur_op, op = SSC_IDLE;
	int mismatches = 0, checks = 0;
	ssc_op_t e_op[N];
	logic [ADDR_W-1:0] e_ad[N];
	logic [3:0] e_ln[N], e_pa[N];
	logic [31:0] e_wd[N];
	logic e_ack[N];
	ssc_if bus ();
	ssc_ctrl_end u_ssc_ctrl_end (.clk_sys, .resetn, .bus(bus.ctrl), .req,
		.req_write, .req_advance, .req_hold, .req_addr, .req_lanes,
		.req_wdata, .req_parity, .ack);
	ssc_mem_end u_ssc_mem_end (.clk_sys, .bus(bus.mem), .burst_interleave,
		.cur_addr, .cur_op, .lane_write_en, .wdata_out, .parity_out);
	ssc_props u_ssc_props (.clk_sys, .resetn, .addr(bus.addr),
		.chip_sel_low_a(bus.chip_sel_low_a), .chip_sel_high(bus.chip_sel_high),
		.chip_sel_low_b(bus.chip_sel_low_b), .write_n(bus.write_n),
		.byte_write_sel_n(bus.byte_write_sel_n),
		.advance_load_n(bus.advance_load_n),
		.clock_qualify_n(bus.clock_qualify_n));
	initial forever #5 clk_sys = ~clk_sys;
	function automatic logic [ADDR_W-1:0] exp_addr(
		input logic [ADDR_W-1:0] b, input logic [1:0] beat,
		input logic ilv);
		exp_addr = {b[ADDR_W-1:2], ilv ? b[1:0] ^ beat : 2'(b[1:0] + beat)};
	endfunction : exp_addr
	task chk(input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			mismatches++;
			$display("[ERR] %0t seen %h want %h", $time, s, e);
		end
	endtask : chk
	task wrap_up;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : wrap_up
	initial begin
		#(N * 10 + 1000);
		mismatches++;
		wrap_up();
	end
	initial begin
		logic r, h, a, w;
		int p;
		void'($urandom(26075));
		repeat (20) @(posedge clk_sys);
		resetn <= 1;
		for (int c = 0; c < N; c++) begin
			@(posedge clk_sys);
			r = $urandom % 10 != 0;
			h = c > 1 && $urandom % 10 == 0;
			a = $urandom % 5 != 0;
			w = $urandom;
			if (c == N / 2 - 1 || c == N / 2) begin
				r = 0;
				h = 0;
			end
			if (c == N / 2)
				il = 1;
			if (a && op != SSC_IDLE)
				w = op == SSC_WRITE;
			req <= r;
			req_hold <= h;
			req_advance <= a;
			req_write <= w;
			req_addr <= $urandom;
			req_lanes <= $urandom;
			req_wdata <= $urandom;
			req_parity <= $urandom;
			burst_interleave <= il;
			#1;
			if (!h && !r)
				op = SSC_IDLE;
			else if (!h && a && op != SSC_IDLE)
				k = k + 2'h1;
			else if (!h) begin
				op = w ? SSC_WRITE : SSC_READ;
				base = req_addr;
				k = 2'h0;
			end
			if (!h && r) begin
				mln = ~req_lanes;
				mwd = req_wdata;
				mpa = req_parity;
			end
			e_op[c] = op;
			e_ad[c] = exp_addr(base, k, il);
			e_ln[c] = op == SSC_WRITE ? ~mln : 4'h0;
			e_wd[c] = mwd;
			e_pa[c] = mpa;
			e_ack[c] = r && !h;
			@(negedge clk_sys);
			if (c > 0)
				chk(ack, e_ack[c - 1]);
			if (c > 1) begin
				p = c - 2;
				chk(cur_op, e_op[p]);
				if (e_op[p] != SSC_IDLE)
					chk(cur_addr, e_ad[p]);
				chk(lane_write_en, e_ln[p]);
				if (e_op[p] == SSC_WRITE) begin
					chk(wdata_out, e_wd[p]);
					chk(parity_out, e_pa[p]);
				end
			end
		end
		$display("random run done");
		wrap_up();
	end
endmodule : sync_sram_command_inputs_tb
